// >>> src/rhg_gate.sv
`timescale 1ns/1ps
// Functional notes
// R1 - A total-failure test runs as soon as the generator starts and a failure blocks all output.
// R2 - A total failure during operation discards every octet built from bits after the failure.
// R3 - The online statistical test runs both at start-up and throughout operation.
// R4 - No octet leaves before the power-up test passes, and none leaves after a defect.
// R5 - The online check runs continuously over fixed blocks so defects show within one block.
// R6 - Random data leaves as 8-bit octets only.
// R7 - Internal bits must carry above 0.997 entropy per bit, 7.976 per octet.
// R8 - Software starts the total-failure test and the device then carries it out.
// R9 - The test outcome is a single pass or fail indication for software.
// R10 - Any failure or defect is held and output stays blocked until a restart passes.
module rhg_gate
    import rhg_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // raw entropy source, asynchronous to clock
    input wire logic raw_bit,
    input wire logic raw_valid,
    // software control
    input wire logic start,
    // software status
    output logic test_done,
    output logic test_pass,
    output logic failed,
    // octet output
    output logic octet_valid,
    output logic [7:0] octet,
    input wire logic octet_ready
);
    rhg_if link();
    rhg_state_e state;
    rhg_state_e next_state;
    logic [1:0] bit_sync;
    logic [1:0] vld_sync;
    logic vld_prev;
    logic bit_strobe;
    logic [10:0] su_cnt;
    logic [10:0] next_su_cnt;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [2:0] sh_cnt;
    logic [2:0] next_sh_cnt;
    logic [7:0] pend;
    logic [7:0] next_pend;
    logic pend_ok;
    logic next_pend_ok;
    logic [7:0] next_octet;
    logic next_octet_valid;
    logic next_test_done;
    logic next_test_pass;
    logic next_failed;

    // two-stage synchronisers for the asynchronous source
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            bit_sync <= 2'b00;
            vld_sync <= 2'b00;
            vld_prev <= 1'b0;
        end
        else
        begin
            bit_sync <= {bit_sync[0], raw_bit};
            vld_sync <= {vld_sync[0], raw_valid};
            vld_prev <= vld_sync[1];
        end
    end

    // one raw bit per rising edge of the source strobe
    assign bit_strobe = vld_sync[1] && !vld_prev;
    assign link.bit_valid = bit_strobe;
    assign link.bit_val = bit_sync[1];
    // monitor restarts on every software start
    assign link.clear = start;

    // R3 continuous monitor
    rhg_monitor u_mon (
        .clock(clock),
        .nrst(nrst),
        .link(link.mon)
    );

    // sequencing, octet assembly and output gating
    always_comb
    begin
        next_state = state;
        next_su_cnt = su_cnt;
        next_shreg = shreg;
        next_sh_cnt = sh_cnt;
        next_pend = pend;
        next_pend_ok = pend_ok;
        next_octet = octet;
        next_octet_valid = octet_valid;
        next_test_done = test_done;
        next_test_pass = test_pass;
        next_failed = failed;
        if (octet_valid && octet_ready)
            next_octet_valid = 1'b0;
        case (state)
            RHG_IDLE:
            begin
                next_octet_valid = 1'b0;
            end
            RHG_TFT, RHG_STARTUP:
            begin
                // R4 nothing leaves before pass
                next_octet_valid = 1'b0;
                if (link.stuck || link.defect)
                begin
                    // R1 failure shows at once
                    next_state = RHG_FAIL;
                    next_failed = 1'b1;
                    next_test_done = 1'b1;
                    next_test_pass = 1'b0;
                end
                else if (bit_strobe && su_cnt != 11'(STARTUP_BITS))
                begin
                    next_su_cnt = su_cnt + 11'h001;
                    // R1 stuck window cleared
                    if (state == RHG_TFT && su_cnt == 11'(STUCK_RUN))
                        next_state = RHG_STARTUP;
                end
                // pass waits for the verdict on the last start-up block, which
                // also lines octet boundaries up with the monitor's blocks
                else if (link.block_done && su_cnt == 11'(STARTUP_BITS))
                begin
                    // R9 pass indication
                    next_state = RHG_RUN;
                    next_test_done = 1'b1;
                    next_test_pass = 1'b1;
                end
            end
            RHG_RUN:
            begin
                if (link.stuck || link.defect)
                begin
                    // R2 drop pending octets
                    next_state = RHG_FAIL;
                    next_pend_ok = 1'b0;
                    next_octet_valid = 1'b0;
                    // status flips in the same edge as the octet is withdrawn
                    next_failed = 1'b1;
                    next_test_done = 1'b1;
                    next_test_pass = 1'b0;
                end
                else
                begin
                    // R6 octet assembly
                    if (bit_strobe)
                    begin
                        next_shreg = {shreg[6:0], link.bit_val};
                        next_sh_cnt = sh_cnt + 3'h1;
                        if (sh_cnt == 3'h7)
                        begin
                            next_pend = {shreg[6:0], link.bit_val};
                            next_pend_ok = 1'b0;
                        end
                    end
                    // released only after the block that holds it passes the test
                    if (link.block_done && sh_cnt == 3'h0 && !bit_strobe)
                        next_pend_ok = 1'b1;
                    if (pend_ok && !next_octet_valid)
                    begin
                        next_octet = pend;
                        next_octet_valid = 1'b1;
                        next_pend_ok = 1'b0;
                    end
                end
            end
            RHG_FAIL:
            begin
                // R10 held until restart
                next_octet_valid = 1'b0;
                next_failed = 1'b1;
                next_test_done = 1'b1;
                next_test_pass = 1'b0;
            end
            default:
            begin
                next_state = RHG_IDLE;
            end
        endcase
        // R8 software start
        if (start)
        begin
            next_state = RHG_TFT;
            next_su_cnt = 11'h000;
            next_sh_cnt = 3'h0;
            next_pend_ok = 1'b0;
            next_octet_valid = 1'b0;
            next_test_done = 1'b0;
            next_test_pass = 1'b0;
            next_failed = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= RHG_IDLE;
            su_cnt <= 11'h000;
            shreg <= OCTET_RST;
            sh_cnt <= 3'h0;
            pend <= OCTET_RST;
            pend_ok <= 1'b0;
            octet <= OCTET_RST;
            octet_valid <= 1'b0;
            test_done <= 1'b0;
            test_pass <= 1'b0;
            failed <= 1'b0;
        end
        else
        begin
            state <= next_state;
            su_cnt <= next_su_cnt;
            shreg <= next_shreg;
            sh_cnt <= next_sh_cnt;
            pend <= next_pend;
            pend_ok <= next_pend_ok;
            octet <= next_octet;
            octet_valid <= next_octet_valid;
            test_done <= next_test_done;
            test_pass <= next_test_pass;
            failed <= next_failed;
        end
    end
endmodule

// >>> src/rhg_if.sv
`timescale 1ns/1ps
interface rhg_if;
    logic bit_valid;
    logic bit_val;
    logic clear;
    logic defect;
    logic stuck;
    logic block_done;
    modport gate (output bit_valid, output bit_val, output clear,
        input defect, input stuck, input block_done);
    modport mon (input bit_valid, input bit_val, input clear,
        output defect, output stuck, output block_done);
endinterface

// >>> src/rhg_monitor.sv
`timescale 1ns/1ps
module rhg_monitor
    import rhg_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // raw bit stream and results
    rhg_if.mon link
);
    logic [6:0] run_cnt;
    logic last_bit;
    logic [8:0] bit_cnt;
    logic [8:0] ones_cnt;
    logic [6:0] next_run_cnt;
    logic next_last_bit;
    logic [8:0] next_bit_cnt;
    logic [8:0] next_ones_cnt;
    logic next_defect;
    logic next_stuck;
    logic next_done;
    logic defect_q;
    logic stuck_q;
    logic done_q;

    // run-length and monobit checks run continuously on every raw bit
    always_comb
    begin
        next_run_cnt = run_cnt;
        next_last_bit = last_bit;
        next_bit_cnt = bit_cnt;
        next_ones_cnt = ones_cnt;
        next_defect = 1'b0;
        next_stuck = 1'b0;
        next_done = 1'b0;
        if (link.clear)
        begin
            next_run_cnt = 7'h00;
            next_bit_cnt = 9'h000;
            next_ones_cnt = 9'h000;
        end
        else if (link.bit_valid)
        begin
            next_last_bit = link.bit_val;
            if (link.bit_val == last_bit && run_cnt != 7'h00)
                next_run_cnt = run_cnt + 7'h01;
            else
                next_run_cnt = 7'h01;
            // a stuck source is a total failure, flagged at once
            if (next_run_cnt >= 7'(STUCK_RUN))
                next_stuck = 1'b1;
            next_ones_cnt = ones_cnt + {8'h00, link.bit_val};
            next_bit_cnt = bit_cnt + 9'h001;
            // R5 R7 monobit block verdict
            if (next_bit_cnt == 9'(BLOCK_BITS))
            begin
                next_done = 1'b1;
                next_defect = (next_ones_cnt < ONES_LO) || (next_ones_cnt > ONES_HI);
                next_bit_cnt = 9'h000;
                next_ones_cnt = 9'h000;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            run_cnt <= 7'h00;
            last_bit <= 1'b0;
            bit_cnt <= 9'h000;
            ones_cnt <= 9'h000;
            defect_q <= 1'b0;
            stuck_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            run_cnt <= next_run_cnt;
            last_bit <= next_last_bit;
            bit_cnt <= next_bit_cnt;
            ones_cnt <= next_ones_cnt;
            defect_q <= next_defect;
            stuck_q <= next_stuck;
            done_q <= next_done;
        end
    end

    assign link.defect = defect_q;
    assign link.stuck = stuck_q;
    assign link.block_done = done_q;
endmodule

// >>> src/rhg_pkg.sv
package rhg_pkg;
    // clock and timing
    localparam int CLK_MHZ = 125;
    // power-up online test length in raw bits
    localparam int STARTUP_BITS = 1024;
    // stuck-source window: this many equal raw bits means total failure
    localparam int STUCK_RUN = 64;
    // periodic online test block length in raw bits
    localparam int BLOCK_BITS = 256;
    // tolerable ones count in a block (monobit bounds)
    localparam logic [8:0] ONES_LO = 9'h054;
    localparam logic [8:0] ONES_HI = 9'h0AC;
    // octet width delivered to software
    localparam int OCTET_W = 8;
    localparam logic [7:0] OCTET_RST = 8'h00;

    typedef enum logic [2:0] {
        RHG_IDLE,
        RHG_TFT,
        RHG_STARTUP,
        RHG_RUN,
        RHG_FAIL
    } rhg_state_e;
endpackage

// >>> tb/rhg_gate_chk.sv
`timescale 1ns/1ps
module rhg_gate_chk
    import rhg_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // source and control
    input wire logic raw_bit,
    input wire logic raw_valid,
    input wire logic start,
    // status
    input wire logic test_done,
    input wire logic test_pass,
    input wire logic failed,
    // octet stream
    input wire logic octet_valid,
    input wire logic [7:0] octet,
    input wire logic octet_ready
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    // everything quiet
    sequence s_clear;
        !test_done && !test_pass && !failed && !octet_valid;
    endsequence
    // octet offered, not taken
    sequence s_stall;
        octet_valid && !octet_ready && !start;
    endsequence
    a_rst_quiet: assert property ($rose(nrst) |-> s_clear)
        else $error("outputs not quiet after reset");
    a_start_clear: assert property (start |=> s_clear)
        else $error("start did not clear status");
    a_fail_block: assert property (failed |-> !octet_valid)
        else $error("octet offered while failed");
    a_test_block: assert property (!test_pass |-> !octet_valid)
        else $error("octet offered before a pass");
    a_fail_held: assert property (failed && !start |=> failed)
        else $error("failure dropped without restart");
    a_done_held: assert property (test_done && !start |=> test_done)
        else $error("done dropped without restart");
    a_pass_done: assert property (test_pass |-> test_done)
        else $error("pass without done");
    a_octet_hold: assert property (s_stall |=> failed || (octet_valid && $stable(octet)))
        else $error("octet changed while stalled");
endmodule

bind rhg_gate rhg_gate_chk u_chk (.clock(clock), .nrst(nrst), .raw_bit(raw_bit),
    .raw_valid(raw_valid), .start(start), .test_done(test_done), .test_pass(test_pass),
    .failed(failed), .octet_valid(octet_valid), .octet(octet), .octet_ready(octet_ready));

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench
    import rhg_pkg::*;
;
    logic clock, nrst, raw_bit, raw_valid, start, octet_ready;
    logic test_done, test_pass, failed, octet_valid;
    logic [7:0] octet;
    logic [2:0] last_st;
    logic [5:0] q_note[$];
    logic [7:0] q_oct[$];
    logic [7:0] hist;
    int n_fail, comparisons, n_oct, seed, seen, bit_idx;

    rhg_gate DUT (.clock(clock), .nrst(nrst), .raw_bit(raw_bit), .raw_valid(raw_valid),
        .start(start), .test_done(test_done), .test_pass(test_pass), .failed(failed),
        .octet_valid(octet_valid), .octet(octet), .octet_ready(octet_ready));

    // free-running clock
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic end_sim();
        $display("counts: %0d compared, %0d wrong", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // note is {expected, mask}; x in a checked status bit never matches
    task automatic cmp_status(input logic [5:0] note, input logic [2:0] got);
        comparisons++;
        if (((got ^ note[5:3]) & note[2:0]) !== 3'h0)
        begin
            n_fail++;
            $display("wrong value at %0t: status %b, expected %b", $time, got, note[5:3]);
        end
    endtask

    task automatic cmp_count(input int got, input int exp_more);
        comparisons++;
        if ((got > seen) != exp_more)
        begin
            n_fail++;
            $display("wrong value at %0t: octet count %0d", $time, got);
        end
        seen = got;
    endtask

    // each accepted octet takes the oldest noted octet
    task automatic cmp_octet(input logic [7:0] got);
        logic [7:0] exp;
        logic hit;
        comparisons++;
        exp = 8'h00;
        hit = q_oct.size() > 0;
        if (hit)
            exp = q_oct.pop_front();
        if (!hit || got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: octet %h, expected %h", $time, got, exp);
        end
    endtask

    // inputs move 1 ns after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // each strobe level held two clocks, consumer stalls at random
    task automatic send_bits(input int n, input int mode);
        logic b;
        for (int k = 0; k < n; k++)
        begin
            b = (mode == 0) ? 1'($random(seed)) : 1'((mode == 1) || (k % 16 != 0));
            hist = {hist[6:0], b};
            bit_idx++;
            // last octet of each clean run block is released, first bit on top
            if (bit_idx > STARTUP_BITS && (bit_idx - STARTUP_BITS) % BLOCK_BITS == 0)
                q_oct.push_back(hist);
            raw_bit = b;
            octet_ready = 1'($random(seed));
            raw_valid = 1'b1;
            tick(2);
            raw_valid = 1'b0;
            tick(2);
        end
    endtask

    task automatic do_start(input logic [5:0] note);
        q_note.push_back(note);
        bit_idx = 0;
        start = 1'b1;
        tick(1);
        start = 1'b0;
    endtask

    // bounded wait for every noted status to show up
    task automatic wait_notes();
        for (int k = 0; k < 20000 && q_note.size() > 0; k++)
            tick(1);
        if (q_note.size() > 0)
        begin
            n_fail++;
            $display("wrong value at %0t: status never arrived", $time);
            end_sim();
        end
    endtask

    // watcher: each change to a nonzero status takes the oldest note
    always @(negedge clock)
    begin
        if (nrst && {test_done, test_pass, failed} !== last_st && {test_done, test_pass, failed} !== 3'h0)
        begin
            if (q_note.size() == 0)
                cmp_status(6'h07, 3'h7);
            else
                cmp_status(q_note.pop_front(), {test_done, test_pass, failed});
        end
        last_st = {test_done, test_pass, failed};
        if (octet_valid === 1'b1 && octet_ready === 1'b1)
        begin
            n_oct++;
            cmp_octet(octet);
        end
    end

    initial
    begin
        seed = 41724;
        n_fail = 0;
        comparisons = 0;
        n_oct = 0;
        seen = 0;
        last_st = 3'h0;
        hist = 8'h00;
        bit_idx = 0;
        {nrst, raw_bit, raw_valid, start, octet_ready} = 5'h00;
        tick(16);
        nrst = 1'b1;
        tick(1);
        // healthy source passes, then octets flow with stalls
        do_start(6'h37);
        send_bits(STARTUP_BITS + 8, 0);
        wait_notes();
        send_bits(4 * BLOCK_BITS, 0);
        // let the last released octet leave before the source is broken
        octet_ready = 1'b1;
        tick(4);
        cmp_count(n_oct, 1);
        comparisons++;
        if (q_oct.size() != 0)
        begin
            n_fail++;
            $display("wrong value at %0t: %0d octets never released", $time, q_oct.size());
        end
        $display("test healthy stream done");
        // source sticks during operation
        q_note.push_back(6'h09);
        send_bits(STUCK_RUN + 8, 1);
        wait_notes();
        // restart on a stuck source
        do_start(6'h2F);
        send_bits(STUCK_RUN + 8, 1);
        wait_notes();
        // restart on a biased source
        do_start(6'h2F);
        send_bits(2 * BLOCK_BITS, 2);
        wait_notes();
        cmp_count(n_oct, 0);
        $display("test failures done");
        // second reset mid-run, then a clean restart
        nrst = 1'b0;
        tick(2);
        nrst = 1'b1;
        tick(1);
        do_start(6'h37);
        send_bits(STARTUP_BITS + 16, 0);
        wait_notes();
        $display("test restart done");
        end_sim();
    end
endmodule
